// ---- sius_consts.vh ----
`ifndef SIUS_CONSTS_VH
`define SIUS_CONSTS_VH

// Register addresses
`define SIUS_ADDR_BREAK_STATUS 16'hfe00
`define SIUS_ADDR_RESET_STATUS 16'hfe01
`define SIUS_ADDR_BREAK_CTRL 16'hfe03
`define SIUS_ADDR_IRQ_LOW 16'hfe04
`define SIUS_ADDR_IRQ_MID 16'hfe05
`define SIUS_ADDR_IRQ_HIGH 16'hfe06

// Field positions
`define SIUS_BIT_BREAK_EXIT 1
`define SIUS_BIT_BREAK_CLEAR_EN 7
`define SIUS_BIT_POR 7
`define SIUS_BIT_PIN 6
`define SIUS_BIT_WDOG 5
`define SIUS_BIT_BAD_OPCODE 4
`define SIUS_BIT_BAD_FETCH 3
`define SIUS_BIT_MONITOR 2
`define SIUS_BIT_LOW_VOLTAGE 1

// Reset values
`define SIUS_RST_BYTE 8'h00
`define SIUS_RST_VEC 5'h00

// Vector codes: 0 none, 1 software interrupt, n+1 for status flag n
`define SIUS_VEC_NONE 5'h00
`define SIUS_VEC_SWI 5'h01

// Stop recovery, in oscillator clock cycles
`define SIUS_REC_LONG 13'd4096
`define SIUS_REC_SHORT 13'd32

`endif

// ---- sius_core_model.sv ----
`timescale 1ns/10ps
module sius_core_model #(
   parameter int ACK_DLY = 6
) (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic int_take_i,
   input wire logic clear_imask_i,
   input wire logic core_clk_en_i,
   output logic instr_done_o,
   output logic imask_o,
   output logic irq_ack_o
);
   logic [1:0] phase;
   int svc;
   // One instruction every four core cycles; no boundary while servicing
   always @(posedge clk_sys_i) begin
      instr_done_o <= 1'b0;
      irq_ack_o <= 1'b0;
      if (!rst_n_i) begin
         phase <= 2'h0;
         svc <= 0;
         imask_o <= 1'b0;
      end else begin
         if (core_clk_en_i && svc == 0) begin
            phase <= phase + 2'h1;
            instr_done_o <= (phase == 2'h3);
         end
         if (int_take_i) begin
            imask_o <= 1'b1;
            svc <= ACK_DLY;
         end else if (svc == 1) begin
            irq_ack_o <= 1'b1;
            imask_o <= 1'b0;
            svc <= 0;
         end else if (svc > 1) begin
            svc <= svc - 1;
         end
         if (clear_imask_i) begin
            imask_o <= 1'b0;
         end
      end
   end
endmodule // sius_core_model

// ---- sius_top.v ----
// Added by the designer: strobed register access.
`timescale 1ns/10ps
`include "sius_consts.vh"

// What this block does
// - Arbitrate sources: break or software interrupt, then flags 1 to 16 in order.
// - Low status register at fe04 is read-only, flags 6..1 in bits 7..2.
// - Each status flag reads 1 while its source requests, else 0.
// - Mid register holds flags 14..7; high holds 16..15, upper bits zero.
// - Reset overrides all interrupts and never takes part in arbitration.
// - Break interrupt forces the software interrupt vector, entering break state.
// - In break, other flags clear only when break clear enable is set.
// - Two-step clears stay blocked in break unless break clear enable is set; second step works after break.
// - Wait or stop clears the interrupt mask and stops core clocks.
// - Wait keeps peripheral clocks; enabled interrupt wakes, stacking in the same cycle.
// - Watchdog runs in wait unless the watchdog disable bit is set.
// - Stop holds counter in reset, all clocks off, generator off unless kept.
// - Interrupt exit from stop waits 4096 oscillator cycles, or 32 if short.
// - Reset exit from stop always waits the long 4096-cycle recovery.
// - Counter held from stop until recovery, clocks resume at its timeout.
// - Break exit flag reads 1 once a break has ended wait or stop mode, until bit 1 is written 0.
// - Reading the reset source register returns flags then clears them all.
// - Separate reset flags for pin, watchdog, opcode, fetch, monitor, low voltage.
// - A latched interrupt holds its vector until serviced or mask cleared.
// - Hardware interrupt taken at instruction end if unmasked and enabled; on wake from wait or stop recovery, if enabled.
// - Break clear enable bit is read/write; 1 allows clearing in break.
module sius_top (
   input wire clk_sys_i,
   input wire rst_n_i,
   input wire [15:0] reg_addr_i,
   input wire [7:0] reg_wdata_i,
   input wire reg_wr_i,
   input wire reg_rd_i,
   output reg [7:0] reg_rdata_o,
   input wire [16:1] irq_req_i,
   input wire [16:1] irq_en_i,
   input wire instr_done_i,
   input wire imask_i,
   input wire software_interrupt_i,
   input wire break_irq_i,
   input wire break_end_i,
   input wire irq_ack_i,
   input wire wait_exec_i,
   input wire stop_exec_i,
   input wire watchdog_disable_i,
   input wire short_recovery_select_i,
   input wire oscillator_run_in_stop_i,
   input wire por_i,
   input wire pin_rst_i,
   input wire wdog_rst_i,
   input wire bad_opcode_i,
   input wire bad_fetch_i,
   input wire monitor_rst_i,
   input wire low_voltage_rst_i,
   output reg int_take_o,
   output reg [4:0] int_vec_o,
   output reg int_latched_o,
   output reg clear_imask_o,
   output reg core_clk_en_o,
   output reg periph_clk_en_o,
   output reg gen_clk_en_o,
   output reg watchdog_run_o,
   output reg break_state_o,
   output reg flag_clear_allow_o,
   output reg recovering_o
);

   localparam ST_RUN = 2'd0;
   localparam ST_WAIT = 2'd1;
   localparam ST_STOP = 2'd2;
   localparam ST_REC = 2'd3;

   reg [1:0] state;
   reg [12:0] rec_cnt;
   reg [12:0] rec_limit;
   reg rec_by_irq;
   reg [16:1] irq_flag;
   reg [7:0] reset_flags;
   reg break_exit_flag;
   reg break_clear_enable;
   reg [4:0] next_vec;
   reg next_pend;
   reg [4:0] hw_vec;
   reg hw_pend;
   reg [7:0] next_rdata;
   reg [7:0] next_reset_flags;
   integer i;
   reg imask_q;
   wire [6:0] cause_sync;

   wire [16:1] hw_req = irq_flag & irq_en_i;
   wire rd_reset = reg_rd_i && (reg_addr_i == `SIUS_ADDR_RESET_STATUS);
   wire wr_break = reg_wr_i && (reg_addr_i == `SIUS_ADDR_BREAK_STATUS);
   wire wr_ctrl = reg_wr_i && (reg_addr_i == `SIUS_ADDR_BREAK_CTRL);
   wire por_s = cause_sync[6];
   wire pin_rst_s = cause_sync[5];
   wire wdog_rst_s = cause_sync[4];
   wire bad_opcode_s = cause_sync[3];
   wire bad_fetch_s = cause_sync[2];
   wire monitor_rst_s = cause_sync[1];
   wire low_voltage_rst_s = cause_sync[0];

   // Reset causes come from pins and analog monitors, so they are resynchronised
   sius_sync2 #(
      .WIDTH(7)
   ) u_cause_sync (
      .clk_i(clk_sys_i),
      .d_i({por_i, pin_rst_i, wdog_rst_i, bad_opcode_i, bad_fetch_i, monitor_rst_i,
         low_voltage_rst_i}),
      .q_o(cause_sync)
   );

   // Previous mask level: a falling mask, like an ack, releases a latched vector
   always @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         imask_q <= 1'b0;
      end else begin
         imask_q <= imask_i;
      end
   end

   // Fixed priority: lowest flag number wins
   always @* begin
      hw_vec = `SIUS_VEC_NONE;
      hw_pend = 1'b0;
      for (i = 16; i >= 1; i = i - 1) begin
         if (hw_req[i]) begin
            hw_vec = i[4:0] + 5'h01;
            hw_pend = 1'b1;
         end
      end
   end

   // Break and software interrupt sit above all flags, both use the same vector
   always @* begin
      next_vec = hw_vec;
      next_pend = hw_pend;
      if (break_irq_i || software_interrupt_i) begin
         next_vec = `SIUS_VEC_SWI;
         next_pend = 1'b1;
      end
   end

   // Request lines sampled each cycle; bus writes never touch them
   always @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         irq_flag <= 16'h0000;
      end else begin
         irq_flag <= irq_req_i;
      end
   end

   // Reset cause capture; kept across system reset, wiped only by power-on or a read
   always @* begin
      next_reset_flags = reset_flags;
      if (rd_reset) begin
         next_reset_flags = `SIUS_RST_BYTE;
      end
      if (pin_rst_s) begin
         next_reset_flags[`SIUS_BIT_PIN] = 1'b1;
      end
      if (wdog_rst_s) begin
         next_reset_flags[`SIUS_BIT_WDOG] = 1'b1;
      end
      if (bad_opcode_s) begin
         next_reset_flags[`SIUS_BIT_BAD_OPCODE] = 1'b1;
      end
      if (bad_fetch_s) begin
         next_reset_flags[`SIUS_BIT_BAD_FETCH] = 1'b1;
      end
      if (monitor_rst_s) begin
         next_reset_flags[`SIUS_BIT_MONITOR] = 1'b1;
      end
      if (low_voltage_rst_s) begin
         next_reset_flags[`SIUS_BIT_LOW_VOLTAGE] = 1'b1;
      end
      if (por_s) begin
         next_reset_flags = `SIUS_RST_BYTE;
         next_reset_flags[`SIUS_BIT_POR] = 1'b1;
         next_reset_flags[`SIUS_BIT_LOW_VOLTAGE] = low_voltage_rst_s;
      end
      next_reset_flags[0] = 1'b0;
   end

   always @(posedge clk_sys_i) begin
      reset_flags <= next_reset_flags;
   end

   // Read mux, data returned one cycle after the strobe
   always @* begin
      next_rdata = `SIUS_RST_BYTE;
      case (reg_addr_i)
         `SIUS_ADDR_BREAK_STATUS: begin
            next_rdata[`SIUS_BIT_BREAK_EXIT] = break_exit_flag;
         end
         `SIUS_ADDR_RESET_STATUS: begin
            next_rdata = reset_flags;
         end
         `SIUS_ADDR_BREAK_CTRL: begin
            next_rdata[`SIUS_BIT_BREAK_CLEAR_EN] = break_clear_enable;
         end
         `SIUS_ADDR_IRQ_LOW: begin
            next_rdata = {irq_flag[6:1], 2'b00};
         end
         `SIUS_ADDR_IRQ_MID: begin
            next_rdata = irq_flag[14:7];
         end
         `SIUS_ADDR_IRQ_HIGH: begin
            next_rdata = {6'h00, irq_flag[16:15]};
         end
         default: begin
            next_rdata = `SIUS_RST_BYTE;
         end
      endcase
   end

   always @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         reg_rdata_o <= `SIUS_RST_BYTE;
      end else if (reg_rd_i) begin
         reg_rdata_o <= next_rdata;
      end else begin
         reg_rdata_o <= `SIUS_RST_BYTE;
      end
   end

   // Break clear enable and break state
   always @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         break_clear_enable <= 1'b0;
         break_state_o <= 1'b0;
         flag_clear_allow_o <= 1'b1;
      end else begin
         if (wr_ctrl) begin
            break_clear_enable <= reg_wdata_i[`SIUS_BIT_BREAK_CLEAR_EN];
         end
         if (break_irq_i) begin
            break_state_o <= 1'b1;
         end else if (break_end_i) begin
            break_state_o <= 1'b0;
         end
         // Peripherals gate both single- and two-step clears with this
         flag_clear_allow_o <= ~break_state_o | break_clear_enable;
      end
   end

   // Low-power sequencing, arbitration latch and stop recovery counter
   always @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         int_take_o <= 1'b0;
         int_vec_o <= `SIUS_RST_VEC;
         int_latched_o <= 1'b0;
         clear_imask_o <= 1'b0;
         break_exit_flag <= 1'b0;
         watchdog_run_o <= ~watchdog_disable_i;
         rec_cnt <= 13'd0;
         rec_by_irq <= 1'b0;
         rec_limit <= `SIUS_REC_LONG;
         if (state == ST_STOP || state == ST_REC) begin
            state <= ST_REC;
            core_clk_en_o <= 1'b0;
            periph_clk_en_o <= 1'b0;
            gen_clk_en_o <= 1'b1;
            recovering_o <= 1'b1;
         end else begin
            state <= ST_RUN;
            core_clk_en_o <= 1'b1;
            periph_clk_en_o <= 1'b1;
            gen_clk_en_o <= 1'b1;
            recovering_o <= 1'b0;
         end
      end else begin
         int_take_o <= 1'b0;
         clear_imask_o <= 1'b0;
         watchdog_run_o <= ~watchdog_disable_i && (state != ST_STOP);
         if (wr_break && !reg_wdata_i[`SIUS_BIT_BREAK_EXIT]) begin
            break_exit_flag <= 1'b0;
         end
         if (int_latched_o && (irq_ack_i || (imask_q && !imask_i))) begin
            int_latched_o <= 1'b0;
         end
         case (state)
            ST_RUN: begin
               if (stop_exec_i) begin
                  state <= ST_STOP;
                  clear_imask_o <= 1'b1;
                  core_clk_en_o <= 1'b0;
                  periph_clk_en_o <= 1'b0;
                  gen_clk_en_o <= oscillator_run_in_stop_i;
                  rec_cnt <= 13'd0;
               end else if (wait_exec_i) begin
                  state <= ST_WAIT;
                  clear_imask_o <= 1'b1;
                  core_clk_en_o <= 1'b0;
               end else if (instr_done_i && !int_latched_o) begin
                  // Flags need unmasked and enabled; break and SOFTWARE_INTERRUPT ignore the mask
                  if (break_irq_i || software_interrupt_i || (hw_pend && !imask_i)) begin
                     int_latched_o <= 1'b1;
                     int_vec_o <= next_vec;
                     int_take_o <= 1'b1;
                  end
               end
            end
            ST_WAIT: begin
               if (next_pend) begin
                  state <= ST_RUN;
                  core_clk_en_o <= 1'b1;
                  int_latched_o <= 1'b1;
                  int_vec_o <= next_vec;
                  int_take_o <= 1'b1;
                  if (break_irq_i) begin
                     break_exit_flag <= 1'b1;
                  end
               end
            end
            ST_STOP: begin
               rec_cnt <= 13'd0;
               if (next_pend) begin
                  state <= ST_REC;
                  recovering_o <= 1'b1;
                  gen_clk_en_o <= 1'b1;
                  rec_by_irq <= 1'b1;
                  if (short_recovery_select_i) begin
                     rec_limit <= `SIUS_REC_SHORT;
                  end else begin
                     rec_limit <= `SIUS_REC_LONG;
                  end
                  if (break_irq_i) begin
                     break_exit_flag <= 1'b1;
                  end
               end
            end
            ST_REC: begin
               if (rec_cnt == rec_limit - 13'd1) begin
                  state <= ST_RUN;
                  recovering_o <= 1'b0;
                  core_clk_en_o <= 1'b1;
                  periph_clk_en_o <= 1'b1;
                  rec_cnt <= 13'd0;
                  rec_by_irq <= 1'b0;
                  if (rec_by_irq && next_pend) begin
                     int_latched_o <= 1'b1;
                     int_vec_o <= next_vec;
                     int_take_o <= 1'b1;
                  end
               end else begin
                  rec_cnt <= rec_cnt + 13'd1;
               end
            end
            default: begin
               state <= ST_RUN;
            end
         endcase
      end
   end

endmodule // sius_top

// Two-flop synchroniser; only the second stage is read outside
module sius_sync2 #(
   parameter WIDTH = 1
) (
   input wire clk_i,
   input wire [WIDTH-1:0] d_i,
   output reg [WIDTH-1:0] q_o
);

   reg [WIDTH-1:0] meta;

   always @(posedge clk_i) begin
      meta <= d_i;
      q_o <= meta;
   end

endmodule // sius_sync2

// ---- sius_top_sva.sv ----
`timescale 1ns/10ps
`include "sius_consts.vh"
module sius_top_sva (
   input wire clk_sys_i,
   input wire rst_n_i,
   input wire [15:0] reg_addr_i,
   input wire reg_rd_i,
   input wire [7:0] reg_rdata_o,
   input wire [16:1] irq_req_i,
   input wire imask_i,
   input wire break_irq_i,
   input wire irq_ack_i,
   input wire wait_exec_i,
   input wire stop_exec_i,
   input wire watchdog_disable_i,
   input wire short_recovery_select_i,
   input wire oscillator_run_in_stop_i,
   input wire int_take_o,
   input wire [4:0] int_vec_o,
   input wire int_latched_o,
   input wire clear_imask_o,
   input wire core_clk_en_o,
   input wire periph_clk_en_o,
   input wire gen_clk_en_o,
   input wire watchdog_run_o,
   input wire break_state_o,
   input wire flag_clear_allow_o,
   input wire recovering_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);
   a_low_reg: assert property (reg_rd_i && reg_addr_i == `SIUS_ADDR_IRQ_LOW
      |=> reg_rdata_o == {$past(irq_req_i[6:1], 2), 2'b00}) else $error("low status bad");
   a_mid_reg: assert property (reg_rd_i && reg_addr_i == `SIUS_ADDR_IRQ_MID
      |=> reg_rdata_o == $past(irq_req_i[14:7], 2)) else $error("mid status bad");
   a_high_reg: assert property (reg_rd_i && reg_addr_i == `SIUS_ADDR_IRQ_HIGH
      |=> reg_rdata_o == {6'h00, $past(irq_req_i[16:15], 2)}) else $error("high status bad");
   a_wait_entry: assert property (wait_exec_i |=> clear_imask_o &&
      !core_clk_en_o && periph_clk_en_o) else $error("wait entry bad");
   a_watchdog_wait: assert property (wait_exec_i |=>
      watchdog_run_o == !watchdog_disable_i) else $error("watchdog in wait bad");
   a_stop_clocks: assert property (stop_exec_i |=> !core_clk_en_o &&
      !periph_clk_en_o && gen_clk_en_o == oscillator_run_in_stop_i) else $error("stop bad");
   a_short_rec: assert property ($rose(recovering_o) && short_recovery_select_i
      |-> !core_clk_en_o [*8] ##[23:27] core_clk_en_o) else $error("short recovery bad");
   a_break_vector: assert property (int_take_o && $past(break_irq_i)
      |-> int_vec_o == `SIUS_VEC_SWI) else $error("break vector bad");
   a_latch_hold: assert property (int_latched_o && imask_i && !irq_ack_i
      |=> int_latched_o && !int_take_o && $stable(int_vec_o)) else $error("latch lost");
   a_clear_allow: assert property (!break_state_o && !$past(break_state_o)
      |-> flag_clear_allow_o) else $error("clear blocked out of break");
endmodule // sius_top_sva
bind sius_top sius_top_sva u_sva (.clk_sys_i, .rst_n_i, .reg_addr_i, .reg_rd_i, .reg_rdata_o,
   .irq_req_i, .imask_i, .break_irq_i, .irq_ack_i, .wait_exec_i, .stop_exec_i,
   .watchdog_disable_i, .short_recovery_select_i, .oscillator_run_in_stop_i, .int_take_o,
   .int_vec_o, .int_latched_o, .clear_imask_o, .core_clk_en_o, .periph_clk_en_o,
   .gen_clk_en_o, .watchdog_run_o, .break_state_o, .flag_clear_allow_o, .recovering_o);

// ---- tb.sv ----
`timescale 1ns/10ps
`include "sius_consts.vh"
module tb;
   logic clk_sys_i = 1'b0, rst_n_i = 1'b0, wr = 1'b0, rd = 1'b0, brk = 1'b0, bend = 1'b0;
   logic wt = 1'b0, stp = 1'b0, wd_dis = 1'b0, short_recovery_select = 1'b0, osc_run = 1'b0, por = 1'b1;
   logic [15:0] addr = 16'h0000;
   logic [7:0] wdata = 8'h00;
   logic [16:1] req = 16'h0000, en = 16'h0000;
   logic [5:0] cause = 6'h00;
   wire [7:0] rdata;
   wire [4:0] vec;
   wire take, latched, clr_im, core_en, per_en, gen_en, brk_st, clr_ok, recov, done, imask, ack;
   wire wdog;
   int n_errors = 0, tests_run = 0, i, j, n, k;
   always #12.5 clk_sys_i = ~clk_sys_i;
   sius_top u_dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .reg_addr_i(addr),
      .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .irq_req_i(req),
      .irq_en_i(en), .instr_done_i(done), .imask_i(imask), .software_interrupt_i(1'b0),
      .break_irq_i(brk), .break_end_i(bend), .irq_ack_i(ack), .wait_exec_i(wt),
      .stop_exec_i(stp), .watchdog_disable_i(wd_dis), .short_recovery_select_i(short_recovery_select),
      .oscillator_run_in_stop_i(osc_run), .por_i(por), .pin_rst_i(cause[5]),
      .wdog_rst_i(cause[4]), .bad_opcode_i(cause[3]), .bad_fetch_i(cause[2]),
      .monitor_rst_i(cause[1]), .low_voltage_rst_i(cause[0]), .int_take_o(take),
      .int_vec_o(vec), .int_latched_o(latched), .clear_imask_o(clr_im),
      .core_clk_en_o(core_en), .periph_clk_en_o(per_en), .gen_clk_en_o(gen_en),
      .watchdog_run_o(wdog), .break_state_o(brk_st), .flag_clear_allow_o(clr_ok),
      .recovering_o(recov));
   sius_core_model #(.ACK_DLY(6)) u_core (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
      .int_take_i(take), .clear_imask_i(clr_im), .core_clk_en_i(core_en),
      .instr_done_o(done), .imask_o(imask), .irq_ack_o(ack));
   task automatic tally_and_finish;
      $display("errors=%0d checks=%0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
         n_errors++;
      end
   endtask
   task automatic cyc(input int c);
      repeat (c) @(posedge clk_sys_i);
   endtask
   task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk_sys_i);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk_sys_i);
      wr <= 1'b0;
   endtask
   task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
      @(posedge clk_sys_i);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_sys_i);
      rd <= 1'b0;
      #1 chk(rdata, e);
   endtask
   // Conditions: 0 take, 1 core clock, 2 recovering, 3 no vector latched
   task automatic wait_sig(input int s, input int lim, output int c);
      c = 0;
      while ((s == 0 ? take : s == 1 ? core_en : s == 2 ? recov : !latched) !== 1'b1) begin
         if (c == lim) begin
            n_errors++;
            tally_and_finish;
         end
         @(posedge clk_sys_i);
         #1 c++;
      end
   endtask
   task automatic sleep(input logic s);
      @(posedge clk_sys_i);
      wt <= !s;
      stp <= s;
      @(posedge clk_sys_i);
      wt <= 1'b0;
      stp <= 1'b0;
   endtask
   function automatic logic [7:0] flags_of(input int b, input logic [16:1] r);
      return b == 0 ? {r[6:1], 2'b00} : b == 1 ? r[14:7] : {6'h00, r[16:15]};
   endfunction
   initial begin
      i = $urandom(7644);
      wd_dis = 1'($urandom);
      osc_run = 1'($urandom);
      cyc(8);
      rst_n_i <= 1'b1;
      por <= 1'b0;
      cyc(2);
      rd_chk(`SIUS_ADDR_RESET_STATUS, 8'h80);
      rd_chk(`SIUS_ADDR_RESET_STATUS, 8'h00);
      for (i = 0; i < 6; i++) begin
         @(posedge clk_sys_i);
         cause <= 6'h01 | (6'h01 << i);
         @(posedge clk_sys_i);
         cause <= 6'h00;
         cyc(2);
         rd_chk(`SIUS_ADDR_RESET_STATUS, 8'h02 | (8'h02 << i));
      end
      for (i = 0; i < 20; i++) begin
         @(posedge clk_sys_i);
         req <= 16'($urandom);
         wr_reg(`SIUS_ADDR_IRQ_LOW + 16'(i % 3), 8'($urandom));
         for (j = 0; j < 3; j++) rd_chk(`SIUS_ADDR_IRQ_LOW + 16'(j), flags_of(j, req));
      end
      rd_chk(16'hfe02, 8'h00);
      @(posedge clk_sys_i);
      req <= 16'h0000;
      en <= 16'hffff;
      for (i = 0; i < 8; i++) begin
         j = $urandom_range(15, 1);
         n = $urandom_range(16, j + 1);
         @(posedge clk_sys_i);
         req <= (16'h1 << (j - 1)) | (16'h1 << (n - 1));
         wait_sig(0, 50, k);
         chk(vec, 16'(j + 1));
         @(posedge clk_sys_i);
         req <= 16'h0000;
         wait_sig(3, 50, k);
      end
      wr_reg(`SIUS_ADDR_BREAK_CTRL, 8'h80);
      rd_chk(`SIUS_ADDR_BREAK_CTRL, 8'h80);
      for (i = 0; i < 2; i++) begin
         if (i == 1) sleep(1'b0);
         @(posedge clk_sys_i);
         brk <= 1'b1;
         wait_sig(0, 50, k);
         chk(vec, `SIUS_VEC_SWI);
         @(posedge clk_sys_i);
         brk <= 1'b0;
         #1 chk({brk_st, clr_ok}, {1'b1, i == 0});
         rd_chk(`SIUS_ADDR_BREAK_STATUS, {6'h00, i == 1, 1'b0});
         wr_reg(`SIUS_ADDR_BREAK_CTRL, 8'h00);
         @(posedge clk_sys_i);
         bend <= 1'b1;
         @(posedge clk_sys_i);
         bend <= 1'b0;
         wait_sig(3, 50, k);
      end
      wr_reg(`SIUS_ADDR_BREAK_STATUS, 8'h00);
      rd_chk(`SIUS_ADDR_BREAK_STATUS, 8'h00);
      sleep(1'b0);
      #1 chk({clr_im, core_en, per_en, wdog}, {3'b101, !wd_dis});
      cyc(5);
      req <= 16'h0010;
      wait_sig(0, 20, k);
      chk(vec, 16'h0006);
      for (i = 0; i < 3; i++) begin
         @(posedge clk_sys_i);
         req <= 16'h0000;
         short_recovery_select <= (i != 1);
         wait_sig(3, 50, k);
         sleep(1'b1);
         #1 chk({core_en, per_en, gen_en}, {2'b00, osc_run});
         cyc(5);
         if (i < 2) req <= 16'h0001;
         else begin
            rst_n_i <= 1'b0;
            cyc(8);
            rst_n_i <= 1'b1;
         end
         wait_sig(2, 20, k);
         wait_sig(1, 5000, n);
         if (i == 0) chk(n >= 30 && n <= 34, 1'b1);
         else chk(n >= 4000 && n <= 4100, 1'b1);
         if (i < 2) wait_sig(0, 10, k);
      end
      tally_and_finish;
   end
endmodule // tb
